// ===== hw/csr_map.svh
// register offsets, field positions, reset values and timing counts for the charger status bank
// Summary of operation
// [RULE1] power-ok bit mirrors pin; host may release
// [RULE2] monitor bit 4 shows disable pin level
// [RULE3] monitor bit 3 flags missing battery
// [RULE4] monitor bit 2 flags background charging
// [RULE5] reserved bits read fixed constant values
// [RULE6] thermistor bit 5 stops zone adjusting charge
// [RULE7] zone flags refresh once every second
// [RULE8] thermistor bit 4 low on input fault
// [RULE9] bits 3..0 show zones above T4..T1
// [RULE10] regulator-on bit resets 1, 0 disables
// [RULE11] watchdog-off bit resets 1, 0 enables
// [RULE12] key write restarts charge after done
// [RULE13] recharge trigger register always reads FFh
// [RULE14] read-only bits and wrong keys ignored
`ifndef CSR_MAP_SVH
`define CSR_MAP_SVH
// register byte offsets
`define CSR_OFF_MONITOR 8'h11
`define CSR_OFF_THERM 8'h12
`define CSR_OFF_WDCTRL 8'h13
`define CSR_OFF_RESTART 8'hfa
// monitor field positions
`define CSR_MON_POWER_OK 5
`define CSR_MON_DISABLE 4
`define CSR_MON_NO_BATT 3
`define CSR_MON_POST_CHG 2
// thermistor field positions
`define CSR_THM_IGNORE 5
`define CSR_THM_SANE 4
// watchdog control field positions and fixed bits
`define CSR_WD_REG_ON 2
`define CSR_WD_OFF 1
`define CSR_WD_FIXED 8'h68
`define CSR_WD_RESET 8'h6e
// recharge trigger key and read value
`define CSR_RESTART_KEY 8'hb5
`define CSR_RESTART_READ 8'hff
// value for reserved or unmapped reads
`define CSR_READ_ZERO 8'h00
// zone refresh timing
`define CSR_CLK_HZ 50000000
`define CSR_ZONE_PERIOD_MS 1000
`define CSR_ZONE_PERIOD_CYC (`CSR_ZONE_PERIOD_MS * (`CSR_CLK_HZ / 1000))
`endif

// ===== hw/csr_pkg.sv
// types shared by the charger status and control register bank
`default_nettype none
package csr_pkg;
  // one register access from the serial port front end
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csr_bus_s;
  // raw thermistor comparator results
  typedef struct packed {
    logic sane;
    logic [3:0] zone;
  } csr_therm_s;
  // control values handed to the charger core
  typedef struct packed {
    logic regulatorOn;
    logic watchdogOff;
    logic thermistorIgnore;
    logic [3:0] appliedZone;
  } csr_ctrl_s;
endpackage : csr_pkg
`default_nettype wire

// ===== hw/csr_status_regs.sv
// status and control register bank of the single-cell charger
`timescale 1ns/1ns
`default_nettype none
`include "csr_map.svh"
module csr_status_regs
  import csr_pkg::*;
#(
  parameter int ZONE_PERIOD_CYC = `CSR_ZONE_PERIOD_CYC
)(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire csr_bus_s regBus,
  output logic [7:0] regRdata,
  input wire logic powerGood,
  input wire logic lowBattery,
  input wire logic powerOkPinIn,
  output logic powerOkPinOut,
  output logic powerOkPinOen,
  input wire logic disablePinLevel,
  input wire logic batteryAbsent,
  input wire logic postChargeActive,
  input wire logic chargeDone,
  input wire csr_therm_s thermIn,
  output csr_ctrl_s ctrl,
  output logic rechargeStart
);
  localparam int CW = $clog2(ZONE_PERIOD_CYC + 1);
  localparam logic [7:0] WD_RESET = `CSR_WD_RESET; // watchdog control value after reset

  // true when the access address names the given register
  function automatic logic isReg(input logic [7:0] addr, input logic [7:0] off);
    isReg = (addr == off);
  endfunction : isReg

  logic rstMeta; // first reset stage
  logic rstSyncN; // released reset used everywhere
  logic powerRelease; // host override letting the pin float
  logic thermistorIgnore; // zone results kept off the charge logic
  logic regulatorOn; // regulator enable
  logic watchdogOff; // watchdog timer disable
  logic [CW-1:0] zoneCount; // cycles until the next zone refresh
  logic zoneTick; // one-cycle refresh strobe
  logic [3:0] zoneFlags; // latched zone flags
  logic thermSane; // latched thermistor sanity
  logic wrMonitor; // write to the monitor register
  logic wrTherm; // write to the thermistor register
  logic wrWdCtrl; // write to the watchdog control register
  logic wrRestart; // write to the recharge trigger
  logic [7:0] next_rdata; // read value for the addressed register

  // reset released through two stages
  // the raw reset pin is read by these two flops only
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rstMeta <= 1'b0;
      rstSyncN <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstSyncN <= rstMeta;
    end
  end

  // write strobes per register
  // a write to an unmapped offset raises no strobe and is dropped
  assign wrMonitor = regBus.write && isReg(regBus.addr, `CSR_OFF_MONITOR);
  assign wrTherm = regBus.write && isReg(regBus.addr, `CSR_OFF_THERM);
  assign wrWdCtrl = regBus.write && isReg(regBus.addr, `CSR_OFF_WDCTRL);
  assign wrRestart = regBus.write && isReg(regBus.addr, `CSR_OFF_RESTART);

  // power-ok release: host sets only while the battery is low
  // a recovered battery wins over a host write in the same cycle
  always_ff @(posedge clk_sys or negedge rstSyncN)
  begin
    if (!rstSyncN)
      powerRelease <= 1'b0;
    // [RULE1] release only below threshold
    else if (!lowBattery)
      powerRelease <= 1'b0;
    else if (wrMonitor)
      powerRelease <= regBus.wdata[`CSR_MON_POWER_OK];
  end

  // open-drain pin: drive low while power is good and not released
  assign powerOkPinOut = 1'b0;
  // enable is low while the pin is driven
  assign powerOkPinOen = !(rstSyncN && powerGood && !powerRelease);

  // thermistor override bit
  // the override only masks what the charger sees, zones keep updating
  always_ff @(posedge clk_sys or negedge rstSyncN)
  begin
    if (!rstSyncN)
      thermistorIgnore <= 1'b0;
    // [RULE14] only the writable bit is kept
    else if (wrTherm)
      thermistorIgnore <= regBus.wdata[`CSR_THM_IGNORE];
  end

  // watchdog and regulator controls
  always_ff @(posedge clk_sys or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      // [RULE10] regulator on after reset
      regulatorOn <= WD_RESET[`CSR_WD_REG_ON];
      // [RULE11] watchdog off after reset
      watchdogOff <= WD_RESET[`CSR_WD_OFF];
    end
    else if (wrWdCtrl)
    begin
      regulatorOn <= regBus.wdata[`CSR_WD_REG_ON];
      watchdogOff <= regBus.wdata[`CSR_WD_OFF];
    end
  end

  // refresh counter, fires right after reset then every period
  // a shorter period keeps simulation short; the default is one second
  always_ff @(posedge clk_sys or negedge rstSyncN)
  begin
    if (!rstSyncN)
      zoneCount <= '0;
    else if (zoneCount == '0)
      zoneCount <= CW'(ZONE_PERIOD_CYC - 1);
    else
      zoneCount <= zoneCount - 1'b1;
  end
  assign zoneTick = (zoneCount == '0);

  // zone and sanity flags sampled once per period, override or not
  always_ff @(posedge clk_sys or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      zoneFlags <= 4'h0;
      thermSane <= 1'b0;
    end
    // [RULE7] periodic zone refresh
    else if (zoneTick)
    begin
      zoneFlags <= thermIn.zone;
      thermSane <= thermIn.sane;
    end
  end

  // controls to the charger core
  assign ctrl.regulatorOn = regulatorOn;
  assign ctrl.watchdogOff = watchdogOff;
  assign ctrl.thermistorIgnore = thermistorIgnore;
  // [RULE6] override hides zones from charging
  assign ctrl.appliedZone = thermistorIgnore ? 4'h0 : zoneFlags;

  // recharge trigger pulse on the key in the done state
  // pulse lasts one cycle; a second key next cycle pulses again
  always_ff @(posedge clk_sys or negedge rstSyncN)
  begin
    if (!rstSyncN)
      rechargeStart <= 1'b0;
    // [RULE12] key restarts charging
    else
      rechargeStart <= wrRestart && chargeDone && (regBus.wdata == `CSR_RESTART_KEY);
  end

  // read value selection
  // unmapped offsets and the monitor and thermistor reserved bits fall through as zero
  always_comb
  begin
    next_rdata = `CSR_READ_ZERO;
    if (isReg(regBus.addr, `CSR_OFF_MONITOR))
    begin
      // [RULE1] bit mirrors the pin level
      next_rdata[`CSR_MON_POWER_OK] = powerOkPinIn;
      // [RULE2] disable pin level
      next_rdata[`CSR_MON_DISABLE] = disablePinLevel;
      // [RULE3] battery absent flag
      next_rdata[`CSR_MON_NO_BATT] = batteryAbsent;
      // [RULE4] background charge flag
      next_rdata[`CSR_MON_POST_CHG] = postChargeActive;
    end
    else if (isReg(regBus.addr, `CSR_OFF_THERM))
    begin
      next_rdata[`CSR_THM_IGNORE] = thermistorIgnore;
      // [RULE8] thermistor sanity
      next_rdata[`CSR_THM_SANE] = thermSane;
      // [RULE9] zone flags
      next_rdata[3:0] = zoneFlags;
    end
    else if (isReg(regBus.addr, `CSR_OFF_WDCTRL))
    begin
      // [RULE5] fixed reserved pattern
      next_rdata = `CSR_WD_FIXED;
      next_rdata[`CSR_WD_REG_ON] = regulatorOn;
      next_rdata[`CSR_WD_OFF] = watchdogOff;
    end
    // [RULE13] trigger always reads all ones
    else if (isReg(regBus.addr, `CSR_OFF_RESTART))
      next_rdata = `CSR_RESTART_READ;
  end

  // read data captured on the read strobe
  always_ff @(posedge clk_sys or negedge rstSyncN)
  begin
    if (!rstSyncN)
      regRdata <= `CSR_READ_ZERO;
    else if (regBus.read)
      regRdata <= next_rdata;
  end

  // checks, all on the system clock and quiet while the released reset is low
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstSyncN);

  // power-ok pin driven while power is good and the battery is fine
  a_power_pin_drive: assert property ( // [RULE1]
    powerGood && !lowBattery ##1 powerGood |-> !powerOkPinOen)
    else $error("power-ok pin not driven");
  // the host release never survives a recovered battery
  a_release_needs_low: assert property ( // [RULE1]
    !lowBattery |=> !powerRelease)
    else $error("pin release kept above threshold");

  // monitor read shows the status levels of the read cycle
  a_monitor_flags_read: assert property ( // [RULE2]
    regBus.read && isReg(regBus.addr, `CSR_OFF_MONITOR)
    |=> regRdata == {2'b00, $past(powerOkPinIn), $past(disablePinLevel), $past(batteryAbsent),
    $past(postChargeActive), 2'b00})
    else $error("monitor read wrong");
  // thermistor read: reserved zeros, override, sanity and zones of the read cycle
  a_therm_reserved: assert property ( // [RULE5]
    regBus.read && isReg(regBus.addr, `CSR_OFF_THERM)
    |=> regRdata == {2'b00, $past(thermistorIgnore), $past(thermSane), $past(zoneFlags)})
    else $error("thermistor read wrong");
  // watchdog read keeps its fixed reserved pattern
  a_wd_fixed_bits: assert property ( // [RULE5]
    regBus.read && isReg(regBus.addr, `CSR_OFF_WDCTRL)
    |=> (regRdata & 8'hf9) == `CSR_WD_FIXED)
    else $error("watchdog reserved bits wrong");
  // watchdog read shows the live control bits
  a_wd_bits_follow: assert property ( // [RULE10]
    regBus.read && isReg(regBus.addr, `CSR_OFF_WDCTRL)
    |=> regRdata[`CSR_WD_REG_ON:`CSR_WD_OFF] == {$past(regulatorOn), $past(watchdogOff)})
    else $error("watchdog control bits not shown");
  // unmapped offsets read as zero
  a_unmapped_zero: assert property ( // [RULE14]
    regBus.read && !isReg(regBus.addr, `CSR_OFF_MONITOR)
    && !isReg(regBus.addr, `CSR_OFF_THERM)
    && !isReg(regBus.addr, `CSR_OFF_WDCTRL) && !isReg(regBus.addr, `CSR_OFF_RESTART)
    |=> regRdata == `CSR_READ_ZERO)
    else $error("unmapped read not zero");

  // override keeps zones away from the charger and follows the host write
  a_ignore_hides: assert property ( // [RULE6]
    thermistorIgnore |-> ctrl.appliedZone == 4'h0)
    else $error("zones leak through override");
  a_ignore_write: assert property ( // [RULE6]
    wrTherm |=> ctrl.thermistorIgnore == $past(regBus.wdata[`CSR_THM_IGNORE]))
    else $error("override bit not written");
  // zones change only on a refresh, and then take the raw levels
  a_zone_hold: assert property ( // [RULE7]
    !zoneTick |=> $stable(zoneFlags) && $stable(thermSane))
    else $error("zones changed between refreshes");
  a_zone_period: assert property ( // [RULE7]
    zoneCount < ZONE_PERIOD_CYC)
    else $error("refresh counter out of range");
  a_zone_sample: assert property ( // [RULE9]
    zoneTick |=> zoneFlags == $past(thermIn.zone))
    else $error("zones not refreshed");
  a_sane_sample: assert property ( // [RULE8]
    zoneTick |=> thermSane == $past(thermIn.sane))
    else $error("sanity not refreshed");

  // regulator and watchdog controls follow writes and hold otherwise
  a_reg_off_write: assert property ( // [RULE10]
    wrWdCtrl && !regBus.wdata[`CSR_WD_REG_ON] |=> !ctrl.regulatorOn)
    else $error("regulator not disabled");
  a_reg_on_write: assert property ( // [RULE10]
    wrWdCtrl && regBus.wdata[`CSR_WD_REG_ON] |=> ctrl.regulatorOn)
    else $error("regulator not enabled");
  a_wd_enable: assert property ( // [RULE11]
    wrWdCtrl && !regBus.wdata[`CSR_WD_OFF] |=> !ctrl.watchdogOff)
    else $error("watchdog not enabled");
  a_wd_disable: assert property ( // [RULE11]
    wrWdCtrl && regBus.wdata[`CSR_WD_OFF] |=> ctrl.watchdogOff)
    else $error("watchdog not disabled");
  a_ctrl_steady: assert property ( // [RULE14]
    !wrWdCtrl |=> $stable(ctrl.regulatorOn) && $stable(ctrl.watchdogOff))
    else $error("controls changed without a write");

  // recharge trigger: key in the done state pulses, anything else stays quiet
  a_restart_key: assert property ( // [RULE12]
    wrRestart && chargeDone && regBus.wdata == `CSR_RESTART_KEY |=> rechargeStart)
    else $error("restart missing");
  a_restart_wrong: assert property ( // [RULE14]
    !(wrRestart && chargeDone && regBus.wdata == `CSR_RESTART_KEY) |=> !rechargeStart)
    else $error("spurious restart");
  a_restart_reads: assert property ( // [RULE13]
    regBus.read && isReg(regBus.addr, `CSR_OFF_RESTART) |=> regRdata == `CSR_RESTART_READ)
    else $error("trigger read not ff");

  // main scenarios
  c_restart: cover property (wrRestart && chargeDone ##1 rechargeStart);
  c_release: cover property (lowBattery && wrMonitor && regBus.wdata[5] ##1 powerOkPinOen);
  c_refresh: cover property (zoneTick ##1 zoneFlags != 4'h0);
  c_override: cover property (wrTherm && regBus.wdata[`CSR_THM_IGNORE] ##1 thermistorIgnore);
  c_reg_off: cover property (wrWdCtrl && !regBus.wdata[`CSR_WD_REG_ON] ##1 !regulatorOn);
endmodule : csr_status_regs
`default_nettype wire

// ===== hw/x_unused_placeholder_removed.sv
// intentionally empty design unit list
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ===== tb/csr_host_model.sv
// host-side model of the open-drain power-ok wire
`timescale 1ns/1ns
`default_nettype none
module csr_host_model (
  input wire logic pinOut,
  input wire logic pinOen,
  output logic pinLevel
);
  // pull-up on open drain
  // low enable pulls the wire, a released pin floats up to 1
  assign pinLevel = pinOen ? 1'b1 : pinOut;
endmodule : csr_host_model
`default_nettype wire

// ===== tb/csr_status_regs_tb.sv
// self-checking bench for the charger status register bank
`timescale 1ns/1ns
`default_nettype none
module csr_status_regs_tb
  import csr_pkg::*;
;
  logic clk_sys = 1'b0; // system clock
  logic resetn; // active-low reset
  csr_bus_s regBus; // byte access strobes
  logic [7:0] regRdata; // read data
  logic powerGood, lowBattery, pinLevel, pinOut, pinOen; // power-ok path
  logic disablePinLevel, batteryAbsent, postChargeActive, chargeDone; // status levels
  csr_therm_s thermIn; // raw comparator levels
  csr_ctrl_s ctrl; // control outputs
  logic rechargeStart; // restart pulse
  int bad_count = 0; // mismatches
  int compares = 0; // comparisons made
  int cycles = 0; // timeout counter
  // 50 MHz clock
  always #10 clk_sys = ~clk_sys;
  csr_status_regs #(.ZONE_PERIOD_CYC(16)) dut_u (.clk_sys(clk_sys), .resetn(resetn),
    .regBus(regBus), .regRdata(regRdata), .powerGood(powerGood), .lowBattery(lowBattery),
    .powerOkPinIn(pinLevel), .powerOkPinOut(pinOut), .powerOkPinOen(pinOen),
    .disablePinLevel(disablePinLevel), .batteryAbsent(batteryAbsent),
    .postChargeActive(postChargeActive), .chargeDone(chargeDone), .thermIn(thermIn),
    .ctrl(ctrl), .rechargeStart(rechargeStart));
  csr_host_model host_u (.pinOut(pinOut), .pinOen(pinOen), .pinLevel(pinLevel));
  // verdict and end of run
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  // byte comparison
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8
  // single bit comparison
  task automatic chk1(input string what, input logic exp, input logic got);
    chk8(what, {7'h00, exp}, {7'h00, got});
  endtask : chk1
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regBus <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    regBus <= '0;
    #1;
  endtask : wr
  // one-cycle read strobe, data checked the cycle after
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    regBus <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    regBus <= '0;
    #1;
    chk8("regRdata", exp, regRdata);
  endtask : rd
  // hang guard
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      bad_count++;
      complete_run();
    end
  end
  // main sequence
  initial
  begin
    regBus = '0;
    {powerGood, lowBattery, disablePinLevel, batteryAbsent} = 4'h0;
    {postChargeActive, chargeDone} = 2'b00;
    thermIn = '0;
    resetn = 1'b0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(8'h13, 8'h6e);
    chk1("regulatorOn", 1'b1, ctrl.regulatorOn);
    chk1("watchdogOff", 1'b1, ctrl.watchdogOff);
    rd(8'hfa, 8'hff);
    rd(8'h40, 8'h00);
    $display("test reset done");
    @(posedge clk_sys);
    {disablePinLevel, batteryAbsent, postChargeActive, powerGood} <= 4'hf;
    rd(8'h11, 8'h1c);
    wr(8'h11, 8'hff);
    rd(8'h11, 8'h1c);
    @(posedge clk_sys);
    lowBattery <= 1'b1;
    wr(8'h11, 8'h20);
    rd(8'h11, 8'h3c);
    chk1("powerOkPinOen", 1'b1, pinOen);
    @(posedge clk_sys);
    lowBattery <= 1'b0;
    rd(8'h11, 8'h1c);
    @(posedge clk_sys);
    lowBattery <= 1'b1;
    wr(8'h11, 8'h20);
    chk1("powerOkPinOen", 1'b1, pinOen);
    wr(8'h11, 8'h00);
    rd(8'h11, 8'h1c);
    @(posedge clk_sys);
    {disablePinLevel, batteryAbsent, postChargeActive, powerGood} <= 4'h0;
    rd(8'h11, 8'h20);
    $display("test monitor done");
    @(posedge clk_sys);
    thermIn <= 5'h1a;
    repeat (20) @(posedge clk_sys);
    rd(8'h12, 8'h1a);
    chk8("appliedZone", 8'h0a, {4'h0, ctrl.appliedZone});
    wr(8'h12, 8'hff);
    chk1("thermistorIgnore", 1'b1, ctrl.thermistorIgnore);
    rd(8'h12, 8'h3a);
    chk8("appliedZone", 8'h00, {4'h0, ctrl.appliedZone});
    @(posedge clk_sys);
    thermIn <= 5'h05;
    repeat (20) @(posedge clk_sys);
    rd(8'h12, 8'h25);
    wr(8'h12, 8'h00);
    chk1("thermistorIgnore", 1'b0, ctrl.thermistorIgnore);
    chk8("appliedZone", 8'h05, {4'h0, ctrl.appliedZone});
    $display("test thermistor done");
    wr(8'h13, 8'h00);
    chk1("regulatorOn", 1'b0, ctrl.regulatorOn);
    chk1("watchdogOff", 1'b0, ctrl.watchdogOff);
    rd(8'h13, 8'h68);
    wr(8'h13, 8'hff);
    rd(8'h13, 8'h6e);
    $display("test watchdog done");
    wr(8'hfa, 8'hb5);
    chk1("rechargeStart", 1'b0, rechargeStart);
    @(posedge clk_sys);
    chargeDone <= 1'b1;
    wr(8'hfa, 8'h12);
    chk1("rechargeStart", 1'b0, rechargeStart);
    wr(8'hfa, 8'hb5);
    chk1("rechargeStart", 1'b1, rechargeStart);
    @(posedge clk_sys);
    #1;
    chk1("rechargeStart", 1'b0, rechargeStart);
    rd(8'hfa, 8'hff);
    $display("test restart done");
    complete_run();
  end
endmodule : csr_status_regs_tb
`default_nettype wire
